/* design/tjoh_top.sv */
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
// Function
// RULE1 - Receive concentrator is 11 bits, two registers
// RULE2 - Debounce needs two matching frames before update
// RULE3 - Hold received fields while out of sync
// RULE4 - Switch bits 5:2, alarm bits 1:0
// RULE5 - Control bit 4 enables two-frame debounce
// RULE6 - Flag bits 3..0 mark stored field change
// RULE7 - Enabled flags drive active-low interrupt
// RULE8 - Mode bit 0 disables frame generation
// RULE9 - ESF data link gets idle or data
// RULE10 - DM channel 24 bit 6 gets HDLC
// RULE11 - SLC overhead replaced from transmit registers
// RULE12 - ESF CRC-6 of previous multiframe inserted
// RULE13 - Concentrator sent LSB first
// RULE14 - Maintenance, switch, alarm sent index-1 first
// RULE15 - Transmit fields need SLC, generation, no bypass
// RULE16 - Auto yellow follows receive red alarm
// RULE17 - Manual yellow inserts unconditionally
// RULE18 - Bit after each F-bit copies it
// RULE19 - Four links at 0x100 spacing
// RULE20 - Alignment toggle slips one transmit bit
// RULE21 - Force all zeros or all ones
// RULE22 - Write one clears a change flag
// RULE23 - Flag only on real stored change
`include "tjoh_regs.svh"
module tjoh_top
    import tjoh_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic [11:0]       bus_addr,
    input  wire logic [7:0]        bus_wdata,
    input  wire logic              bus_wr,
    input  wire logic              bus_rd,
    output logic      [7:0]        bus_rdata,
    output logic                   irq_n,
    input  wire logic [3:0]        j1_mode,
    input  wire logic [7:0]        fmt_sel,
    input  wire logic [3:0]        rx_slc_sync,
    input  wire logic [3:0]        rx_red_alarm,
    input  wire logic [3:0]        rx_oh_strobe,
    input  wire tjoh_oh_t [3:0]    rx_oh,
    input  wire logic [3:0]        tx_bit_en,
    input  wire logic [3:0]        tx_din,
    input  wire logic [3:0]        tx_hdlc_bit,
    input  wire logic [3:0]        tx_hdlc_valid,
    output logic      [3:0]        tx_dout,
    output logic      [3:0]        tx_yellow
);
    // Address bits 11:10 must be zero; bits 9:8 select the link
    function automatic logic hit(input logic [11:0] a, input logic [7:0] off, input logic [1:0] l);
        hit = (a[11:10] == 2'b00) && (a[9:8] == l) && (a[7:0] == off);
    endfunction : hit

    logic [7:0]  rdata_mux [0:3];
    logic [3:0]  irq_vec;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_link
            tjoh_fmt_t fmt;
            assign fmt = tjoh_fmt_t'(fmt_sel[2*g +: 2]);

            logic [7:0] irq_en_reg, mode_reg, m0_reg, m1_reg;
            logic [3:0] flags_reg, flags_next;
            tjoh_oh_t   st_reg, pend_reg, st_next, tx_oh_reg;
            logic       pend_ok_reg;

            wire w_en  = bus_wr && hit(bus_addr, `TJOH_OFF_IRQ_EN, 2'(g)); // RULE19
            wire w_fl  = bus_wr && hit(bus_addr, `TJOH_OFF_FLAGS, 2'(g));
            wire w_md  = bus_wr && hit(bus_addr, `TJOH_OFF_MODE, 2'(g));
            wire w_m0  = bus_wr && hit(bus_addr, `TJOH_OFF_MAINT0, 2'(g));
            wire w_m1  = bus_wr && hit(bus_addr, `TJOH_OFF_MAINT1, 2'(g));
            wire w_tc  = bus_wr && hit(bus_addr, `TJOH_OFF_TX_CONC_LO, 2'(g));
            wire w_tm  = bus_wr && hit(bus_addr, `TJOH_OFF_TX_MAINT, 2'(g));
            wire w_ts  = bus_wr && hit(bus_addr, `TJOH_OFF_TX_SW_AL, 2'(g));

            wire debounce = irq_en_reg[`TJOH_BIT_DEBOUNCE]; // RULE5
            wire upd_ok   = rx_oh_strobe[g] && rx_slc_sync[g]; // RULE3
            wire match    = pend_ok_reg && (pend_reg == rx_oh[g]);
            wire take     = upd_ok && (!debounce || match); // RULE2
            assign st_next = take ? rx_oh[g] : st_reg;
            wire [3:0] chg = {st_next.alarm != st_reg.alarm, st_next.sw != st_reg.sw,
                              st_next.maint != st_reg.maint, st_next.conc != st_reg.conc}; // RULE6 RULE23
            // Set wins over a same-cycle clear
            assign flags_next = (flags_reg & ~(w_fl ? bus_wdata[3:0] : 4'h0)) | chg; // RULE22
            assign irq_vec[g] = |(flags_reg & irq_en_reg[3:0]); // RULE7

            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    st_reg      <= '0;
                    pend_reg    <= '0;
                    pend_ok_reg <= 1'b0;
                    flags_reg   <= 4'h0;
                end else begin
                    st_reg    <= st_next;
                    flags_reg <= flags_next;
                    if (upd_ok) begin
                        pend_reg    <= rx_oh[g];
                        pend_ok_reg <= 1'b1;
                    end else if (!rx_slc_sync[g]) begin
                        pend_ok_reg <= 1'b0;
                    end
                end
            end

            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    irq_en_reg <= `TJOH_RESET_BYTE;
                    mode_reg   <= `TJOH_RESET_BYTE;
                    m0_reg     <= `TJOH_RESET_BYTE;
                    m1_reg     <= `TJOH_RESET_BYTE;
                    tx_oh_reg  <= '0;
                end else begin
                    if (w_en) irq_en_reg <= {3'h0, bus_wdata[4:0]};
                    if (w_md) mode_reg   <= {5'h0, bus_wdata[2:0]};
                    if (w_m0) m0_reg     <= {2'h0, bus_wdata[5:4], 4'h0};
                    if (w_m1) m1_reg     <= {4'h0, bus_wdata[3:0]};
                    if (w_tc) tx_oh_reg.conc[7:0] <= bus_wdata;
                    if (w_tm) begin
                        tx_oh_reg.conc[10:8] <= bus_wdata[2:0];
                        tx_oh_reg.maint      <= bus_wdata[5:3];
                    end
                    if (w_ts) begin
                        tx_oh_reg.sw    <= bus_wdata[5:2];
                        tx_oh_reg.alarm <= bus_wdata[1:0];
                    end
                end
            end

            // Transmit frame position counters, CRC, idle pattern, slip and F-bit copy state
            logic [7:0] bit_reg;
            logic [6:0] frm_reg;
            logic [5:0] crc_reg, crc_prev_reg;
            logic [3:0] idle_reg;
            logic [7:0] lfsr_reg;
            logic       align_q_reg, slip_pend_reg, slip_rep_reg, last_bit_reg, last_f_reg;
            logic [4:0] oh_idx_reg;

            wire gen_on   = !mode_reg[`TJOH_BIT_FRAME_GEN_DISABLE]; // RULE8
            wire dl_byp   = mode_reg[`TJOH_BIT_DLBYP];
            wire crc_byp  = mode_reg[`TJOH_BIT_CRC_INSERT_BYPASS];
            wire is_f     = (bit_reg == 8'd0);
            wire [6:0] mlen = (fmt == TJOH_FMT_SLC) ? `TJOH_SLC_FRAMES : 7'(`TJOH_ESF_FRAMES);
            wire esf_dl   = is_f && !frm_reg[0];
            wire esf_crc  = is_f && (frm_reg[1:0] == 2'd1);
            // Data link on odd ESF frames when counted from one
            wire [4:0] ci = 5'(frm_reg[6:2]);
            // Twenty odd frames from 33 on, so all twenty overhead bits fit
            wire slc_oh   = is_f && frm_reg[0] && (frm_reg >= 7'd33);
            wire [4:0] oi = oh_idx_reg;
            // Conc, maint, switch, alarm in turn, each lowest index first
            wire [19:0] tx_flat = {tx_oh_reg.alarm, tx_oh_reg.sw, tx_oh_reg.maint, tx_oh_reg.conc}; // RULE13 RULE14
            wire sel_bit  = tx_flat[oi];
            // Bit 6 of channel 24 lies five places after the channel's first bit
            wire dm_d     = (bit_reg == 8'd190);
            wire [15:0] idle = j1_mode[g] ? `TJOH_IDLE_J1 : `TJOH_IDLE_T1;
            logic base;
            always_comb begin
                base = tx_din[g];
                if (gen_on) begin
                    if (fmt == TJOH_FMT_ESF && esf_dl && !dl_byp)
                        base = tx_hdlc_valid[g] ? tx_hdlc_bit[g] : idle[idle_reg]; // RULE9
                    else if (fmt == TJOH_FMT_ESF && esf_crc && !crc_byp)
                        base = crc_prev_reg[3'(ci % 5'd6)]; // RULE12
                    else if (fmt == TJOH_FMT_DM && dm_d && !dl_byp)
                        base = tx_hdlc_bit[g]; // RULE10
                    else if (fmt == TJOH_FMT_SLC && slc_oh && !dl_byp)
                        base = sel_bit; // RULE11 RULE15
                    else if (bit_reg == 8'd1 && m1_reg[`TJOH_BIT_MIMIC])
                        base = last_f_reg; // RULE18
                end
                if (slip_rep_reg) base = last_bit_reg; // RULE20
                if (m1_reg[`TJOH_BIT_ZEROS]) base = 1'b0; // RULE21
                else if (m1_reg[`TJOH_BIT_ONES]) base = 1'b1;
            end
            wire slip_now = slip_pend_reg && tx_bit_en[g] && lfsr_reg[0];
            wire slip_rep = slip_now && lfsr_reg[1];
            // A deletion steps over one position; it may be the F position that is lost
            wire [8:0] bit_step = {1'b0, bit_reg} + ((slip_now && !lfsr_reg[1]) ? 9'd2 : 9'd1);
            wire       bit_wrap = bit_step >= 9'(`TJOH_FRAME_BITS);
            wire [8:0] bit_fold = bit_step - 9'(`TJOH_FRAME_BITS);

            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    bit_reg       <= 8'd0;
                    frm_reg       <= 7'd0;
                    crc_reg       <= 6'h0;
                    crc_prev_reg  <= 6'h0;
                    idle_reg      <= 4'h0;
                    lfsr_reg      <= `TJOH_LFSR_SEED;
                    align_q_reg   <= 1'b0;
                    slip_pend_reg <= 1'b0;
                    slip_rep_reg  <= 1'b0;
                    last_bit_reg  <= 1'b0;
                    last_f_reg    <= 1'b0;
                    oh_idx_reg    <= 5'h0;
                    tx_dout[g]    <= 1'b0;
                    tx_yellow[g]  <= 1'b0;
                end else begin
                    lfsr_reg    <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
                    align_q_reg <= m1_reg[`TJOH_BIT_ALIGN];
                    if (align_q_reg != m1_reg[`TJOH_BIT_ALIGN]) slip_pend_reg <= 1'b1; // RULE20
                    else if (slip_now) slip_pend_reg <= 1'b0;
                    tx_yellow[g] <= m0_reg[`TJOH_BIT_MAN_YEL] ||
                                    (m0_reg[`TJOH_BIT_AUTO_YEL] && rx_red_alarm[g]); // RULE16 RULE17
                    if (tx_bit_en[g]) begin
                        tx_dout[g]   <= base;
                        last_bit_reg <= base;
                        slip_rep_reg <= slip_rep;
                        if (is_f) last_f_reg <= base;
                        if (fmt == TJOH_FMT_ESF && esf_dl) idle_reg <= idle_reg + 4'd1;
                        if (slc_oh) oh_idx_reg <= (oh_idx_reg == 5'd19) ? 5'd0 : oh_idx_reg + 5'd1;
                        crc_reg <= {crc_reg[4:0], 1'b0} ^ ((crc_reg[5] ^ base) ? 6'h03 : 6'h00);
                        // Deletion skips a bit position; repetition holds the counter
                        if (!slip_rep) begin
                            if (bit_wrap) begin
                                bit_reg <= bit_fold[7:0];
                                if (frm_reg == mlen - 7'd1) begin
                                    frm_reg <= 7'd0;
                                    crc_prev_reg <= crc_reg;
                                    crc_reg <= 6'h0;
                                    oh_idx_reg <= 5'h0;
                                end else begin
                                    frm_reg <= frm_reg + 7'd1;
                                end
                            end else begin
                                bit_reg <= bit_step[7:0];
                            end
                        end
                    end
                end
            end

            logic [7:0] rsel;
            always_comb begin
                rsel = 8'h00;
                if (hit(bus_addr, `TJOH_OFF_RX_CONC_LO, 2'(g))) rsel = st_reg.conc[7:0]; // RULE1
                if (hit(bus_addr, `TJOH_OFF_RX_MAINT, 2'(g)))   rsel = {2'h0, st_reg.maint, st_reg.conc[10:8]};
                if (hit(bus_addr, `TJOH_OFF_RX_SW_AL, 2'(g)))   rsel = {2'h0, st_reg.sw, st_reg.alarm}; // RULE4
                if (hit(bus_addr, `TJOH_OFF_IRQ_EN, 2'(g)))     rsel = irq_en_reg;
                if (hit(bus_addr, `TJOH_OFF_FLAGS, 2'(g)))      rsel = {4'h0, flags_reg};
                if (hit(bus_addr, `TJOH_OFF_MODE, 2'(g)))       rsel = mode_reg;
                if (hit(bus_addr, `TJOH_OFF_TX_CONC_LO, 2'(g))) rsel = tx_oh_reg.conc[7:0];
                if (hit(bus_addr, `TJOH_OFF_TX_MAINT, 2'(g)))   rsel = {2'h0, tx_oh_reg.maint, tx_oh_reg.conc[10:8]};
                if (hit(bus_addr, `TJOH_OFF_TX_SW_AL, 2'(g)))   rsel = {2'h0, tx_oh_reg.sw, tx_oh_reg.alarm};
                if (hit(bus_addr, `TJOH_OFF_MAINT0, 2'(g)))     rsel = m0_reg;
                if (hit(bus_addr, `TJOH_OFF_MAINT1, 2'(g)))     rsel = m1_reg;
            end
            assign rdata_mux[g] = rsel;
        end
    endgenerate

    // Unmapped addresses read as zero
    wire [7:0] rd_any = rdata_mux[0] | rdata_mux[1] | rdata_mux[2] | rdata_mux[3];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bus_rdata <= 8'h00;
            irq_n     <= 1'b1;
        end else begin
            bus_rdata <= bus_rd ? rd_any : 8'h00;
            irq_n     <= ~(|irq_vec); // RULE7
        end
    end
endmodule : tjoh_top

/* include/tjoh_regs.svh */
`ifndef TJOH_REGS_SVH
`define TJOH_REGS_SVH
`define TJOH_LINK_STRIDE     12'h100
`define TJOH_OFF_RX_CONC_LO  8'h56
`define TJOH_OFF_RX_MAINT    8'h57
`define TJOH_OFF_RX_SW_AL    8'h58
`define TJOH_OFF_IRQ_EN      8'h5c
`define TJOH_OFF_FLAGS       8'h5d
`define TJOH_OFF_MODE        8'h62
`define TJOH_OFF_TX_CONC_LO  8'h65
`define TJOH_OFF_TX_MAINT    8'h66
`define TJOH_OFF_TX_SW_AL    8'h67
`define TJOH_OFF_MAINT0      8'h6b
`define TJOH_OFF_MAINT1      8'h6c
`define TJOH_BIT_DEBOUNCE    4
`define TJOH_BIT_FRAME_GEN_DISABLE        0
`define TJOH_BIT_CRC_INSERT_BYPASS      1
`define TJOH_BIT_DLBYP       2
`define TJOH_BIT_AUTO_YEL    5
`define TJOH_BIT_MAN_YEL     4
`define TJOH_BIT_MIMIC       3
`define TJOH_BIT_ALIGN       2
`define TJOH_BIT_ZEROS       1
`define TJOH_BIT_ONES        0
`define TJOH_RESET_BYTE      8'h00
`define TJOH_IDLE_T1         16'hffff
`define TJOH_IDLE_J1         16'hff7e
`define TJOH_FRAME_BITS      8'd193
`define TJOH_ESF_FRAMES      5'd24
`define TJOH_SLC_FRAMES      7'd72
`define TJOH_LFSR_SEED       8'ha5
`endif

/* include/tjoh_pkg.sv */
package tjoh_pkg;
    typedef enum logic [1:0] {
        TJOH_FMT_SF  = 2'h0,
        TJOH_FMT_ESF = 2'h1,
        TJOH_FMT_DM  = 2'h3,
        TJOH_FMT_SLC = 2'h2
    } tjoh_fmt_t;

    typedef struct packed {
        logic [10:0] conc;
        logic [2:0]  maint;
        logic [3:0]  sw;
        logic [1:0]  alarm;
    } tjoh_oh_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } tjoh_bus_t;
endpackage : tjoh_pkg

/* verification/tjoh_far_end.sv */
`timescale 1ns/100ps
// Far line terminal: hands over one received overhead set per request, after a random gap
module tjoh_far_end
    import tjoh_pkg::*;
(
    input  wire logic            core_clk,
    input  wire logic            sys_rst,
    input  wire logic            go,
    input  wire logic [1:0]      link,
    input  wire logic [2:0]      gap,
    input  wire tjoh_oh_t        val,
    output logic      [3:0]      rx_oh_strobe,
    output tjoh_oh_t  [3:0]      rx_oh
);
    logic [2:0] cnt_reg;
    logic       pend_reg;
    logic [1:0] lk_reg;
    tjoh_oh_t   val_reg;
    // Fields toggle outside the strobe so a stale sample can never pass for a match
    always_ff @(posedge core_clk) begin
        rx_oh_strobe <= 4'h0;
        rx_oh <= ~rx_oh;
        if (sys_rst) begin
            pend_reg <= 1'b0;
            cnt_reg <= 3'h0;
            rx_oh <= '0;
        end else if (go) begin
            pend_reg <= 1'b1;
            cnt_reg <= gap;
            lk_reg <= link;
            val_reg <= val;
        end else if (pend_reg && cnt_reg == 3'h0) begin
            pend_reg <= 1'b0;
            rx_oh_strobe[lk_reg] <= 1'b1;
            rx_oh[lk_reg] <= val_reg;
        end else if (pend_reg) begin
            cnt_reg <= cnt_reg - 3'h1;
        end
    end
endmodule : tjoh_far_end

/* verification/tjoh_top_asserts.sv */
`timescale 1ns/100ps
module tjoh_top_asserts (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic [11:0] bus_addr,
    input wire logic        bus_wr,
    input wire logic        bus_rd,
    input wire logic [7:0]  bus_rdata,
    input wire logic        irq_n,
    input wire logic [3:0]  rx_slc_sync,
    input wire logic [3:0]  rx_red_alarm,
    input wire logic [3:0]  rx_oh_strobe,
    input wire logic [3:0]  tx_bit_en,
    input wire logic [3:0]  tx_dout,
    input wire logic [3:0]  tx_yellow
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    rdata_idle_a: assert property (!bus_rd |=> bus_rdata == 8'h00)
        else $error("read data not zero outside a read");
    unmapped_zero_a: assert property (bus_rd && bus_addr[11:10] != 2'b00 |=> bus_rdata == 8'h00)
        else $error("unmapped read returned data");
    switch_rsvd_a: assert property (bus_rd && bus_addr[7:0] == 8'h58 |=> bus_rdata[7:6] == 2'b00)
        else $error("switch alarm register top bits set");
    flag_rsvd_a: assert property (bus_rd && bus_addr[7:0] == 8'h5d |=> bus_rdata[7:4] == 4'h0)
        else $error("change flag register top bits set");
    irq_cause_a: assert property ($fell(irq_n) |-> $past(|(rx_oh_strobe & rx_slc_sync), 2) || $past(bus_wr, 2))
        else $error("interrupt asserted without cause");
    irq_clear_a: assert property ($rose(irq_n) |-> $past(bus_wr, 2))
        else $error("interrupt released without a write");
    dout_hold_a: assert property (tx_bit_en == 4'h0 |=> $stable(tx_dout))
        else $error("transmit bit moved without bit enable");
    yellow_cause_a: assert property ((tx_yellow & ~$past(tx_yellow)) != 4'h0 |->
        $past(rx_red_alarm) != 4'h0 || $past(bus_wr, 2)) else $error("yellow raised without cause");
    cover property (|(rx_oh_strobe & rx_slc_sync));
    cover property ($fell(irq_n));
    cover property (tx_yellow != 4'h0);
endmodule : tjoh_top_asserts
bind tjoh_top tjoh_top_asserts tjoh_top_asserts_i (.core_clk(core_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq_n(irq_n), .rx_slc_sync(rx_slc_sync),
    .rx_red_alarm(rx_red_alarm), .rx_oh_strobe(rx_oh_strobe), .tx_bit_en(tx_bit_en), .tx_dout(tx_dout),
    .tx_yellow(tx_yellow));

/* verification/testbench.sv */
`timescale 1ns/100ps
module testbench;
    import tjoh_pkg::*;
    logic           core_clk, sys_rst, bus_wr, bus_rd, irq_n, pv_go, tlf;
    logic [11:0]    bus_addr;
    logic [7:0]     bus_wdata, bus_rdata, rd_val, fmt_sel, f;
    logic [3:0]     j1_mode, rx_slc_sync, rx_red_alarm, rx_oh_strobe, tx_bit_en, tx_din;
    logic [3:0]     tx_hdlc_bit, tx_hdlc_valid, tx_dout, tx_yellow;
    logic [1:0]     lk, pv_link;
    logic [2:0]     pv_gap;
    tjoh_oh_t [3:0] rx_oh;
    tjoh_oh_t       pv_val, s, x;
    int             n_errors, num_checks, tp, tf, tk;
    logic [7:0]     offs[11] = '{8'h56, 8'h57, 8'h58, 8'h5c, 8'h5d, 8'h62, 8'h65, 8'h66, 8'h67, 8'h6b, 8'h6c};
    logic [7:0]     msk[11] = '{8'h00, 8'h00, 8'h00, 8'h1f, 8'h00, 8'h07, 8'hff, 8'h3f, 8'h3f, 8'h30, 8'h0f};
    logic [7:0]     exp_rw[4][11];
    tjoh_top tjoh_top_i (.core_clk(core_clk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq_n(irq_n), .j1_mode(j1_mode),
        .fmt_sel(fmt_sel), .rx_slc_sync(rx_slc_sync), .rx_red_alarm(rx_red_alarm), .rx_oh_strobe(rx_oh_strobe),
        .rx_oh(rx_oh), .tx_bit_en(tx_bit_en), .tx_din(tx_din), .tx_hdlc_bit(tx_hdlc_bit),
        .tx_hdlc_valid(tx_hdlc_valid), .tx_dout(tx_dout), .tx_yellow(tx_yellow));
    tjoh_far_end tjoh_far_end_i (.core_clk(core_clk), .sys_rst(sys_rst), .go(pv_go), .link(pv_link),
        .gap(pv_gap), .val(pv_val), .rx_oh_strobe(rx_oh_strobe), .rx_oh(rx_oh));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task stop_test;
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stop_test
    task automatic chk8(string what, logic [7:0] e, logic [7:0] got);
        num_checks++;
        if (got !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, got);
        end
    endtask : chk8
    function automatic logic [11:0] ad(logic [1:0] l, logic [7:0] o);
        return {2'b00, l, o};
    endfunction : ad
    function automatic logic [7:0] chg(tjoh_oh_t a, tjoh_oh_t b);
        return {4'h0, a.alarm != b.alarm, a.sw != b.sw, a.maint != b.maint, a.conc != b.conc};
    endfunction : chg
    task automatic wr(logic [11:0] a, logic [7:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge core_clk);
        bus_wr <= 1'b0;
    endtask : wr
    task automatic rchk(string what, logic [11:0] a, logic [7:0] e);
        @(posedge core_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge core_clk);
        bus_rd <= 1'b0;
        #1 chk8(what, e, bus_rdata);
    endtask : rchk
    task automatic rx_chk(logic [1:0] l, tjoh_oh_t e);
        rchk("rx conc low", ad(l, 8'h56), e.conc[7:0]);
        rchk("rx maint conc high", ad(l, 8'h57), {2'b00, e.maint, e.conc[10:8]});
        rchk("rx switch alarm", ad(l, 8'h58), {2'b00, e.sw, e.alarm});
    endtask : rx_chk
    // Gap of 0..3 cycles exercises prompt and slow far-end delivery
    task automatic send(logic [1:0] l, tjoh_oh_t v);
        @(posedge core_clk);
        pv_link <= l;
        pv_val <= v;
        pv_gap <= 3'($urandom_range(0, 3));
        pv_go <= 1'b1;
        @(posedge core_clk);
        pv_go <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask : send
    task automatic tx_run(logic e);
        repeat (10) begin
            @(posedge core_clk);
            tx_bit_en <= 4'hf;
            tx_din <= 4'($urandom);
            tx_hdlc_bit <= 4'($urandom);
            @(posedge core_clk);
            tx_bit_en <= 4'h0;
            #1 chk8("tx_dout", 8'(e), 8'(tx_dout[lk]));
        end
    endtask : tx_run
    task automatic yel(logic e);
        repeat (3) @(posedge core_clk);
        #1 chk8("tx_yellow", 8'(e), 8'(tx_yellow[lk]));
    endtask : yel
    // Expected bit at bit tp of frame tf; copy of the F bit assumes the copy is switched on
    function automatic logic tx_exp(logic [1:0] fm, logic din, logic hb, logic [19:0] oh);
        if (fm == 2'h1 && tp == 0 && tf % 2 == 0) return hb;
        if (fm == 2'h3 && tp == 190) return hb;
        if (fm == 2'h2 && tp == 0 && tf % 2 == 1 && tf >= 33) return oh[tk];
        if (tp == 1) return tlf;
        return din;
    endfunction : tx_exp
    // Framer position is kept across calls, so formats may change between frames
    task automatic tx_frames(logic [1:0] fm, int nfr, logic [19:0] oh);
        logic e;
        repeat (nfr * 193) begin
            @(posedge core_clk);
            tx_bit_en <= 4'hf;
            tx_din <= 4'($urandom);
            tx_hdlc_bit <= 4'($urandom);
            @(posedge core_clk);
            tx_bit_en <= 4'h0;
            e = tx_exp(fm, tx_din[lk], tx_hdlc_bit[lk], oh);
            #1 chk8("tx frame bit", 8'(e), 8'(tx_dout[lk]));
            if (tp == 0) tlf = e;
            if (fm == 2'h2 && tp == 0 && tf % 2 == 1 && tf >= 33) tk++;
            tp = (tp + 1) % 193;
            if (tp == 0) tf = (tf + 1) % (fm == 2'h2 ? 72 : 24);
            if (tp == 0 && tf == 0) tk = 0;
        end
    endtask : tx_frames
    initial begin
        repeat (40000) @(posedge core_clk);
        n_errors++;
        stop_test;
    end
    initial begin
        void'($urandom(32'h34ee));
        {bus_wr, bus_rd, pv_go, bus_addr, bus_wdata, pv_link, pv_gap, pv_val} = '0;
        {j1_mode, rx_slc_sync, rx_red_alarm, tx_bit_en, tx_din, tx_hdlc_bit, tx_hdlc_valid} = '0;
        fmt_sel = 8'haa;
        n_errors = 0;
        num_checks = 0;
        sys_rst = 1'b1;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        foreach (exp_rw[l, i]) rchk("reset value", ad(2'(l), offs[i]), 8'h00);
        foreach (exp_rw[l, i]) begin
            exp_rw[l][i] = 8'($urandom);
            wr(ad(2'(l), offs[i]), exp_rw[l][i]);
            exp_rw[l][i] &= msk[i];
        end
        foreach (exp_rw[l, i]) rchk("readback", ad(2'(l), offs[i]), exp_rw[l][i]);
        foreach (exp_rw[l, i]) wr(ad(2'(l), offs[i]), 8'h00);
        rchk("unmapped", 12'h45c, 8'h00);
        lk = 2'($urandom);
        rx_slc_sync <= 4'hf;
        wr(ad(lk, 8'h5c), 8'h0f);
        x = tjoh_oh_t'(20'($urandom) | 20'h04891);
        send(lk, x);
        rx_chk(lk, x);
        rchk("flags", ad(lk, 8'h5d), 8'h0f);
        chk8("irq_n", 8'h00, 8'(irq_n));
        wr(ad(lk, 8'h5d), 8'h0f);
        rchk("flags", ad(lk, 8'h5d), 8'h00);
        chk8("irq_n", 8'h01, 8'(irq_n));
        send(lk, x);
        rchk("flags", ad(lk, 8'h5d), 8'h00);
        rx_slc_sync[lk] <= 1'b0;
        send(lk, ~x);
        rx_chk(lk, x);
        rx_slc_sync[lk] <= 1'b1;
        wr(ad(lk, 8'h5c), 8'h18);
        send(lk, ~x);
        rx_chk(lk, x);
        send(lk, ~x);
        rx_chk(lk, ~x);
        rchk("flags", ad(lk, 8'h5d), 8'h0f);
        wr(ad(lk, 8'h5c), 8'h08);
        wr(ad(lk, 8'h5d), 8'h0f);
        s = ~x;
        s.sw = x.sw;
        send(lk, s);
        rchk("flags", ad(lk, 8'h5d), 8'h04);
        chk8("irq_n", 8'h01, 8'(irq_n));
        repeat (12) begin
            x = tjoh_oh_t'(20'($urandom));
            rx_slc_sync[lk] <= 1'($urandom);
            wr(ad(lk, 8'h5d), 8'h0f);
            send(lk, x);
            f = rx_slc_sync[lk] ? chg(s, x) : 8'h00;
            if (rx_slc_sync[lk]) s = x;
            rx_chk(lk, s);
            rchk("flags", ad(lk, 8'h5d), f);
        end
        wr(ad(lk, 8'h62), 8'h01);
        wr(ad(lk, 8'h6c), 8'h02);
        tx_run(1'b0);
        wr(ad(lk, 8'h6c), 8'h01);
        tx_run(1'b1);
        wr(ad(lk, 8'h6b), 8'h10);
        yel(1'b1);
        wr(ad(lk, 8'h6b), 8'h20);
        yel(1'b0);
        rx_red_alarm[lk] <= 1'b1;
        yel(1'b1);
        wr(ad(lk, 8'h6b), 8'h00);
        yel(1'b0);
        // Second reset puts the framer back at bit 0 of frame 0
        sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        fmt_sel <= 8'hff;
        tx_hdlc_valid <= 4'hf;
        rchk("reset value", ad(lk, 8'h6c), 8'h00);
        wr(ad(lk, 8'h6c), 8'h08);
        tx_frames(2'h3, 2, 20'h0);
        fmt_sel <= 8'h55;
        wr(ad(lk, 8'h62), 8'h02);
        tx_frames(2'h1, 4, 20'h0);
        fmt_sel <= 8'haa;
        x = tjoh_oh_t'(20'($urandom));
        wr(ad(lk, 8'h62), 8'h00);
        wr(ad(lk, 8'h65), x.conc[7:0]);
        wr(ad(lk, 8'h66), {2'b00, x.maint, x.conc[10:8]});
        wr(ad(lk, 8'h67), {2'b00, x.sw, x.alarm});
        tx_frames(2'h2, 66, {x.alarm, x.sw, x.maint, x.conc});
        stop_test;
    end
endmodule : testbench
